/* File: src/srer_top.sv */
// Function
// R1 - sector number: address 7:0 or 31:24 by selector
// R2 - cylinder low: address 15:8 or 39:32
// R3 - cylinder high: address 23:16 or 47:40
// R4 - time limit overrun sets error bit 0
// R5 - error with stream option sets status bit 5
// R6 - stream error loads failing address and count
// R7 - stream option: log errors, clear ERR
// R8 - count: current low byte, previous high byte
// R9 - selector bit chooses high or low byte
`default_nettype none
module srer_top
  import srer_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk_in,      // 40 MHz clock
  input  wire logic              arst_n_in,       // async reset, low
  input  wire logic              cmd_start_in,    // command issued, pulse
  input  wire logic              rc_in,           // stream option at issue
  input  wire logic              cmd_done_in,     // command ended, pulse
  input  wire logic              unc_in,          // uncorrectable error
  input  wire logic              idnf_in,         // id not found
  input  wire logic              abrt_in,         // aborted
  input  wire logic [47:0]       err_lba_in,      // first failing address
  input  wire logic [15:0]       bad_cnt_in,      // sectors maybe bad
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in, // write address
  input  wire logic              s_axi_awvalid_in, // write address valid
  output logic                   s_axi_awready_out, // write address ready
  input  wire logic [31:0]       s_axi_wdata_in,  // write data
  input  wire logic [3:0]        s_axi_wstrb_in,  // byte enables
  input  wire logic              s_axi_wvalid_in, // write data valid
  output logic                   s_axi_wready_out, // write data ready
  output logic [1:0]             s_axi_bresp_out, // write response
  output logic                   s_axi_bvalid_out, // response valid
  input  wire logic              s_axi_bready_in, // response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in, // read address
  input  wire logic              s_axi_arvalid_in, // read address valid
  output logic                   s_axi_arready_out, // read address ready
  output logic [31:0]            s_axi_rdata_out, // read data
  output logic [1:0]             s_axi_rresp_out, // read response
  output logic                   s_axi_rvalid_out, // read data valid
  input  wire logic              s_axi_rready_in, // read data ready
  output logic                   irq_out          // level interrupt
);
  if (ADDR_W < 8 || ADDR_W > 32)
  begin : g_chk
    $error("ADDR_W must lie between 8 and 32");
  end

  // ==========================================================
  // helpers
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    // upper address bits must be clear; the cast also serves ADDR_W == 8
    hit = (a == ADDR_W'(off));
  endfunction

  function automatic logic [7:0] merge8(input logic [7:0] old_v,
                                        input logic [7:0] new_v,
                                        input logic       en);
    merge8 = en ? new_v : old_v;
  endfunction

  // ==========================================================
  // state
  srer_cmd_e   cmd_r;
  logic        rc_r;
  logic [47:0] lba_r;
  logic [15:0] cnt_r;
  logic [7:0]  err_reg_r;
  logic [7:0]  log_r;
  logic        se_r;
  logic        errf_r;
  logic [7:0]  devctl_r;
  logic [7:0]  irq_stat_r;
  logic [7:0]  irq_mask_r;
  logic [15:0] tlimit_r;
  logic [15:0] elapsed_r;
  logic [$clog2(TICK_CYC+1)-1:0] tick_cnt_r;

  // ==========================================================
  // command timing
  wire run_w    = (cmd_r == CMD_RUN);
  wire tick_w   = (tick_cnt_r == ($clog2(TICK_CYC+1))'(TICK_CYC - 1));
  wire done_ev  = run_w && cmd_done_in;
  // a limit of zero disables the watchdog; a real completion in the
  // same cycle as the overrun wins, so no false timeout is reported
  wire to_ev    = run_w && !cmd_done_in && (tlimit_r != '0)
                  && (elapsed_r >= tlimit_r);                 // [R4]
  wire fin_ev   = done_ev || to_ev;
  wire unc_w    = done_ev && unc_in;
  wire idnf_w   = done_ev && idnf_in;
  wire abrt_w   = done_ev && abrt_in;
  wire any_err  = unc_w || idnf_w || abrt_w || to_ev;
  wire se_ev    = fin_ev && rc_r && any_err;                  // [R5]

  logic [7:0] err_bits_w;
  always_comb
  begin
    err_bits_w = '0;
    err_bits_w[ERR_CCTO_BIT] = to_ev;                         // [R4]
    err_bits_w[ERR_ABRT_BIT] = abrt_w;
    err_bits_w[ERR_IDNF_BIT] = idnf_w;
    err_bits_w[ERR_UNC_BIT]  = unc_w;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cmd_r      <= CMD_IDLE;
      rc_r       <= 1'b0;
      tick_cnt_r <= '0;
      elapsed_r  <= '0;
    end
    else
    begin
      if (cmd_start_in && !run_w)
      begin
        cmd_r      <= CMD_RUN;
        rc_r       <= rc_in;
        tick_cnt_r <= '0;
        elapsed_r  <= '0;
      end
      else if (fin_ev)
        cmd_r <= CMD_IDLE;
      else if (run_w)
      begin
        tick_cnt_r <= tick_w ? '0 : tick_cnt_r + 1'b1;
        if (tick_w && elapsed_r != '1)
          elapsed_r <= elapsed_r + 16'h0001;
      end
    end
  end

  // ==========================================================
  // completion results
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      lba_r     <= '0;
      cnt_r     <= '0;
      err_reg_r <= '0;
      log_r     <= '0;
      se_r      <= 1'b0;
      errf_r    <= 1'b0;
    end
    else if (cmd_start_in && !run_w)
    begin
      se_r      <= 1'b0;
      errf_r    <= 1'b0;
      err_reg_r <= '0;
    end
    else if (fin_ev)
    begin
      lba_r <= err_lba_in;                                 // [R1] [R6]
      cnt_r <= se_ev ? bad_cnt_in : '0;                    // [R6] [R8]
      if (se_ev)
      begin
        se_r      <= 1'b1;                                 // [R5] [R7]
        errf_r    <= 1'b0;                                 // [R7]
        err_reg_r <= '0;                                   // [R7]
        log_r     <= err_bits_w;                           // [R7]
      end
      else
      begin
        se_r      <= 1'b0;
        errf_r    <= any_err;
        err_reg_r <= err_bits_w;                           // [R4]
      end
    end
  end

  // ==========================================================
  // register views
  wire       hob_w     = devctl_r[DC_HOB_BIT];                  // [R9]
  wire [7:0] secnum_w  = hob_w ? lba_r[SN_HI_LSB +: 8]
                               : lba_r[SN_LO_LSB +: 8];         // [R1]
  wire [7:0] cyl_lo_w  = hob_w ? lba_r[CL_HI_LSB +: 8]
                               : lba_r[CL_LO_LSB +: 8];         // [R2]
  wire [7:0] cyl_hi_w  = hob_w ? lba_r[CH_HI_LSB +: 8]
                               : lba_r[CH_LO_LSB +: 8];         // [R3]
  wire [7:0] seccnt_w  = hob_w ? cnt_r[CNT_HI_LSB +: 8]
                               : cnt_r[7:0];                    // [R8]

  logic [7:0] status_w;
  always_comb
  begin
    status_w = '0;
    status_w[ST_ERR_BIT] = errf_r;
    status_w[ST_SE_BIT]  = se_r;                                // [R5]
    status_w[ST_RDY_BIT] = 1'b1;
    status_w[ST_BSY_BIT] = run_w;
  end

  // ==========================================================
  // AXI4-Lite slave: one write and one read in flight
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              aw_got_r;
  logic              w_got_r;

  wire aw_hs  = s_axi_awvalid_in && s_axi_awready_out;
  wire w_hs   = s_axi_wvalid_in && s_axi_wready_out;
  wire ar_hs  = s_axi_arvalid_in && s_axi_arready_out;
  wire b_hs   = s_axi_bvalid_out && s_axi_bready_in;
  wire r_hs   = s_axi_rvalid_out && s_axi_rready_in;
  wire wr_go  = aw_got_r && w_got_r;
  wire wr_dc  = hit(aw_addr_r, OFF_DEVCTL);
  wire wr_msk = hit(aw_addr_r, OFF_IRQ_MASK);
  wire wr_lim = hit(aw_addr_r, OFF_TLIMIT);
  // read-only registers answer OKAY and ignore the data
  wire wr_map = wr_dc || wr_msk || wr_lim
                || hit(aw_addr_r, OFF_SECNUM) || hit(aw_addr_r, OFF_CYL_LO)
                || hit(aw_addr_r, OFF_CYL_HI) || hit(aw_addr_r, OFF_SECCNT)
                || hit(aw_addr_r, OFF_ERROR) || hit(aw_addr_r, OFF_STATUS)
                || hit(aw_addr_r, OFF_ERRLOG)
                || hit(aw_addr_r, OFF_IRQ_STAT);

  wire rd_stat = ar_hs && hit(s_axi_araddr_in, OFF_IRQ_STAT);
  wire [7:0] rd_byte =
      hit(s_axi_araddr_in, OFF_SECNUM)   ? secnum_w   :
      hit(s_axi_araddr_in, OFF_CYL_LO)   ? cyl_lo_w   :
      hit(s_axi_araddr_in, OFF_CYL_HI)   ? cyl_hi_w   :
      hit(s_axi_araddr_in, OFF_SECCNT)   ? seccnt_w   :
      hit(s_axi_araddr_in, OFF_ERROR)    ? err_reg_r  :
      hit(s_axi_araddr_in, OFF_STATUS)   ? status_w   :
      hit(s_axi_araddr_in, OFF_DEVCTL)   ? devctl_r   :
      hit(s_axi_araddr_in, OFF_ERRLOG)   ? log_r      :
      hit(s_axi_araddr_in, OFF_IRQ_STAT) ? irq_stat_r :
      hit(s_axi_araddr_in, OFF_IRQ_MASK) ? irq_mask_r : 8'h00;
  wire [31:0] rd_word = hit(s_axi_araddr_in, OFF_TLIMIT)
                        ? {16'h0000, tlimit_r} : {24'h000000, rd_byte};
  wire rd_map = (rd_byte != 8'h00) || hit(s_axi_araddr_in, OFF_TLIMIT)
                || (s_axi_araddr_in <= ADDR_W'(OFF_TLIMIT)
                    && s_axi_araddr_in[1:0] == 2'h0);

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= RESP_OKAY;
      aw_got_r          <= 1'b0;
      w_got_r           <= 1'b0;
      aw_addr_r         <= '0;
      w_data_r          <= '0;
      w_strb_r          <= '0;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_addr_r         <= s_axi_awaddr_in;
        aw_got_r          <= 1'b1;
        s_axi_awready_out <= 1'b0;
      end
      if (w_hs)
      begin
        w_data_r         <= s_axi_wdata_in;
        w_strb_r         <= s_axi_wstrb_in;
        w_got_r          <= 1'b1;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_go)
      begin
        aw_got_r         <= 1'b0;
        w_got_r          <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_map ? RESP_OKAY : RESP_SLV;
      end
      if (b_hs)
      begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= '0;
      s_axi_rresp_out   <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= rd_word;
      s_axi_rresp_out   <= rd_map ? RESP_OKAY : RESP_SLV;
    end
    else if (r_hs)
    begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // ==========================================================
  // control registers and interrupt
  logic [7:0] irq_ev_w;
  always_comb
  begin
    irq_ev_w = '0;
    irq_ev_w[IRQ_DONE_BIT] = fin_ev;
    irq_ev_w[IRQ_SE_BIT]   = se_ev;
    irq_ev_w[IRQ_TO_BIT]   = to_ev;
  end
  // an event in the same cycle as the clearing read survives
  wire [7:0] irq_stat_nxt = (rd_stat ? 8'h00 : irq_stat_r) | irq_ev_w;

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      devctl_r   <= DEVCTL_RST;
      irq_mask_r <= MASK_RST;
      tlimit_r   <= TLIMIT_RST;
      irq_stat_r <= '0;
      irq_out    <= 1'b0;
    end
    else
    begin
      if (wr_go && wr_dc)
        devctl_r <= merge8(devctl_r, w_data_r[7:0], w_strb_r[0]); // [R9]
      if (wr_go && wr_msk)
        irq_mask_r <= merge8(irq_mask_r, w_data_r[7:0], w_strb_r[0]);
      if (wr_go && wr_lim)
        tlimit_r <= {merge8(tlimit_r[15:8], w_data_r[15:8], w_strb_r[1]),
                     merge8(tlimit_r[7:0], w_data_r[7:0], w_strb_r[0])};
      irq_stat_r <= irq_stat_nxt;
      irq_out    <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  // read data holds the value from the read edge, even if a completion
  // reloads the results in that same cycle
  sequence s_rd_sel(logic [7:0] off, logic h);
    ar_hs && hit(s_axi_araddr_in, off) && hob_w == h;
  endsequence

  a_secnum_low: assert property (s_rd_sel(OFF_SECNUM, 1'b0) |=>   // [R1]
    s_axi_rdata_out[7:0] == $past(lba_r[7:0]))
    else $error("sector number low byte wrong");
  a_secnum_high: assert property (s_rd_sel(OFF_SECNUM, 1'b1) |=>  // [R1]
    s_axi_rdata_out[7:0] == $past(lba_r[31:24]))
    else $error("sector number high byte wrong");
  a_cyl_low_sel: assert property (s_rd_sel(OFF_CYL_LO, 1'b1) |=>  // [R2]
    s_axi_rdata_out[7:0] == $past(lba_r[39:32]))
    else $error("cylinder low high byte wrong");
  a_cyl_high_sel: assert property (s_rd_sel(OFF_CYL_HI, 1'b0) |=> // [R3]
    s_axi_rdata_out[7:0] == $past(lba_r[23:16]))
    else $error("cylinder high low byte wrong");
  a_ccto_sets: assert property (to_ev && !rc_r |=>                // [R4]
    err_reg_r[ERR_CCTO_BIT] && status_w[ST_ERR_BIT])
    else $error("time limit overrun not flagged");
  a_stream_se: assert property (se_ev |=> se_r && !errf_r         // [R5]
    && err_reg_r == 8'h00 ##1 status_w[ST_SE_BIT] || cmd_r == CMD_RUN)
    else $error("stream error not reported");
  a_stream_load: assert property (se_ev |=>                      // [R6]
    lba_r == $past(err_lba_in) && cnt_r == $past(bad_cnt_in))
    else $error("stream error address or count not loaded");
  a_stream_log: assert property (se_ev |=> log_r == $past(err_bits_w)
    && log_r != 8'h00)                                            // [R7]
    else $error("stream error bits not logged");
  a_count_pair: assert property (s_rd_sel(OFF_SECCNT, 1'b1) |=>   // [R8]
    s_axi_rdata_out[7:0] == $past(cnt_r[15:8]))
    else $error("previous count byte wrong");
  a_hob_write: assert property (wr_go && wr_dc && w_strb_r[0] |=> // [R9]
    hob_w == $past(w_data_r[DC_HOB_BIT]))
    else $error("selector bit not stored");
  a_irq_level: assert property (irq_stat_r != 8'h00
    && (irq_stat_r & irq_mask_r) != 8'h00 && !rd_stat |=> irq_out)
    else $error("interrupt not raised");
endmodule
`default_nettype wire

/* File: src/srer_pkg.sv */
`default_nettype none
package srer_pkg;
  // ==========================================================
  // register map, byte addresses of aligned 32-bit words
  localparam logic [7:0] OFF_SECNUM   = 8'h00;
  localparam logic [7:0] OFF_CYL_LO   = 8'h04;
  localparam logic [7:0] OFF_CYL_HI   = 8'h08;
  localparam logic [7:0] OFF_SECCNT   = 8'h0C;
  localparam logic [7:0] OFF_ERROR    = 8'h10;
  localparam logic [7:0] OFF_STATUS   = 8'h14;
  localparam logic [7:0] OFF_DEVCTL   = 8'h18;
  localparam logic [7:0] OFF_ERRLOG   = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFF_TLIMIT   = 8'h28;
  // ==========================================================
  // byte positions inside the 48-bit address and 16-bit count
  localparam int SN_LO_LSB  = 0;
  localparam int SN_HI_LSB  = 24;
  localparam int CL_LO_LSB  = 8;
  localparam int CL_HI_LSB  = 32;
  localparam int CH_LO_LSB  = 16;
  localparam int CH_HI_LSB  = 40;
  localparam int CNT_HI_LSB = 8;
  // ==========================================================
  // bit positions
  localparam int ERR_CCTO_BIT = 0;
  localparam int ERR_ABRT_BIT = 2;
  localparam int ERR_IDNF_BIT = 4;
  localparam int ERR_UNC_BIT  = 6;
  localparam int ST_ERR_BIT   = 0;
  localparam int ST_SE_BIT    = 5;
  localparam int ST_RDY_BIT   = 6;
  localparam int ST_BSY_BIT   = 7;
  localparam int DC_HOB_BIT   = 7;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_SE_BIT   = 1;
  localparam int IRQ_TO_BIT   = 2;
  // ==========================================================
  // reset values and bus answers
  localparam logic [7:0]  DEVCTL_RST = 8'h00;
  localparam logic [7:0]  MASK_RST   = 8'h00;
  localparam logic [15:0] TLIMIT_RST = 16'h0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
  // ==========================================================
  // timing: time limit counts in ticks of one microsecond
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic {CMD_IDLE, CMD_RUN} srer_cmd_e;
endpackage
`default_nettype wire

/* File: dv/srer_host.sv */
`default_nettype none
// ==========================================================
// host side: task-file reads and writes over the register bus
module srer_host
(
  input  wire logic        clk_in,      // bus clock
  output logic [7:0]       awaddr_out,  // aw
  output logic             awvalid_out, // aw
  input  wire logic        awready_in,  // aw
  output logic [31:0]      wdata_out,   // w
  output logic [3:0]       wstrb_out,   // w
  output logic             wvalid_out,  // w
  input  wire logic        wready_in,   // w
  input  wire logic [1:0]  bresp_in,    // b
  input  wire logic        bvalid_in,   // b
  output logic             bready_out,  // b
  output logic [7:0]       araddr_out,  // ar
  output logic             arvalid_out, // ar
  input  wire logic        arready_in,  // ar
  input  wire logic [31:0] rdata_in,    // r
  input  wire logic [1:0]  rresp_in,    // r
  input  wire logic        rvalid_in,   // r
  output logic             rready_out   // r
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    {awaddr_out, awvalid_out, wdata_out, wvalid_out} = '0;
    {bready_out, araddr_out, arvalid_out, rready_out} = '0;
    wstrb_out = 4'hF;
  end

  // released payload shows its inverse so stale data cannot pass
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r, output logic to);
    int n;
    n = 0;
    @(posedge clk_in);
    awaddr_out  <= a;
    wdata_out   <= d;
    awvalid_out <= 1'h1;
    wvalid_out  <= 1'h1;
    bready_out  <= 1'h1;
    do
    begin
      @(posedge clk_in);
      n++;
      if (awready_in)
        awvalid_out <= 1'h0;
      if (wready_in)
        wvalid_out <= 1'h0;
    end while (!bvalid_in && n < 100);
    r = bresp_in;
    to = !bvalid_in;
    {awvalid_out, wvalid_out, bready_out} <= 3'h0;
    awaddr_out <= ~a;
    wdata_out  <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r, output logic to);
    int n;
    n = 0;
    @(posedge clk_in);
    araddr_out  <= a;
    arvalid_out <= 1'h1;
    rready_out  <= 1'h1;
    do
    begin
      @(posedge clk_in);
      n++;
      if (arready_in)
        arvalid_out <= 1'h0;
    end while (!rvalid_in && n < 100);
    d = rdata_in;
    r = rresp_in;
    to = !rvalid_in;
    {arvalid_out, rready_out} <= 2'h0;
    araddr_out <= ~a;
  endtask
endmodule
`default_nettype wire

/* File: dv/test_stream_read_error_report.sv */
`default_nettype none
module test_stream_read_error_report
  import srer_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, arst_n, cmd_start, rc, cmd_done, unc, idnf, abrt;
  logic [47:0] err_lba;
  logic [15:0] bad_cnt;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc = 0;

  srer_top DUT (
    .ref_clk_in(clk), .arst_n_in(arst_n), .cmd_start_in(cmd_start),
    .rc_in(rc), .cmd_done_in(cmd_done), .unc_in(unc), .idnf_in(idnf),
    .abrt_in(abrt), .err_lba_in(err_lba), .bad_cnt_in(bad_cnt),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .irq_out(irq));

  srer_host host (
    .clk_in(clk), .awaddr_out(awaddr), .awvalid_out(awvalid),
    .awready_in(awready), .wdata_out(wdata), .wstrb_out(wstrb),
    .wvalid_out(wvalid), .wready_in(wready), .bresp_in(bresp),
    .bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr),
    .arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata),
    .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));

  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  // ==========================================================
  // checking and bus helpers
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic close_out();
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    logic        t;
    host.rd(a, d, r, t);
    error_cnt += t;
    if (t)
      close_out();
    cmp(d, e);
    cmp({30'h0, r}, {30'h0, er});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic [1:0] r;
    logic       t;
    host.wr(a, d, r, t);
    error_cnt += t;
    if (t)
      close_out();
    cmp({30'h0, r}, {30'h0, er});
  endtask

  // irq is registered on the same edge as the status bits but one edge behind the mask, so let two edges pass
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    cmp({31'h0, irq}, {31'h0, e});
  endtask

  // e is {unc, idnf, abrt}; fin low leaves the time limit to end it
  task automatic run_cmd(input logic r, input logic [2:0] e,
                         input logic [47:0] l, input logic [15:0] c,
                         input logic fin);
    @(posedge clk);
    rc        <= r;
    cmd_start <= 1'h1;
    err_lba   <= l;
    bad_cnt   <= c;
    @(posedge clk);
    cmd_start        <= 1'h0;
    {unc, idnf, abrt} <= e;
    rd(OFF_STATUS, 32'hC0, RESP_OKAY);
    if (fin)
    begin
      @(posedge clk);
      cmd_done <= 1'h1;
      @(posedge clk);
      cmd_done <= 1'h0;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic sc_reset();
    rd(OFF_DEVCTL, 32'h0, RESP_OKAY);
    rd(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
    rd(OFF_TLIMIT, 32'h0, RESP_OKAY);
    rd(OFF_STATUS, 32'h40, RESP_OKAY);
    rd(8'h2C, 32'h0, RESP_SLV);
    wr(8'h2C, 32'h1, RESP_SLV);
    wr(OFF_ERROR, 32'hFF, RESP_OKAY);
    rd(OFF_ERROR, 32'h0, RESP_OKAY);
    irq_is(1'h0);
  endtask

  task automatic sc_plain();
    run_cmd(1'h0, 3'h4, 48'hA5B4C3D2E1F0, 16'h1234, 1'h1);
    rd(OFF_SECNUM, 32'hF0, RESP_OKAY);
    rd(OFF_CYL_LO, 32'hE1, RESP_OKAY);
    rd(OFF_CYL_HI, 32'hD2, RESP_OKAY);
    rd(OFF_ERROR, 32'h40, RESP_OKAY);
    rd(OFF_STATUS, 32'h41, RESP_OKAY);
    irq_is(1'h0);
    wr(OFF_DEVCTL, 32'h80, RESP_OKAY);
    rd(OFF_SECNUM, 32'hC3, RESP_OKAY);
    rd(OFF_CYL_LO, 32'hB4, RESP_OKAY);
    rd(OFF_CYL_HI, 32'hA5, RESP_OKAY);
    wr(OFF_DEVCTL, 32'h0, RESP_OKAY);
    wr(OFF_IRQ_MASK, 32'h7, RESP_OKAY);
    irq_is(1'h1);
    rd(OFF_IRQ_STAT, 32'h1, RESP_OKAY);
    irq_is(1'h0);
  endtask

  task automatic sc_stream();
    for (int i = 0; i < 3; i++)
    begin
      run_cmd(1'h1, 3'h4 >> i, 48'h0102030405A6, 16'h9C6D, 1'h1);
      rd(OFF_STATUS, 32'h60, RESP_OKAY);
      rd(OFF_ERROR, 32'h0, RESP_OKAY);
      rd(OFF_ERRLOG, 32'h40 >> (2 * i), RESP_OKAY);
      rd(OFF_SECNUM, 32'hA6, RESP_OKAY);
      rd(OFF_SECCNT, 32'h6D, RESP_OKAY);
    end
    irq_is(1'h1);
    wr(OFF_DEVCTL, 32'h80, RESP_OKAY);
    rd(OFF_SECCNT, 32'h9C, RESP_OKAY);
    rd(OFF_CYL_HI, 32'h01, RESP_OKAY);
    wr(OFF_DEVCTL, 32'h0, RESP_OKAY);
    rd(OFF_IRQ_STAT, 32'h3, RESP_OKAY);
    irq_is(1'h0);
  endtask

  task automatic sc_timeout(input logic r);
    logic [31:0] d;
    logic [1:0]  rs;
    logic        t;
    int          n;
    int          t0;
    n = 0;
    wr(OFF_TLIMIT, 32'h2, RESP_OKAY);
    t0 = cyc;
    run_cmd(r, 3'h0, 48'h0, 16'h0, 1'h0);
    do
    begin
      host.rd(OFF_STATUS, d, rs, t);
      error_cnt += t;
      if (t)
        close_out();
      n++;
    end while (d[ST_BSY_BIT] !== 1'b0 && n < 100);
    cmp({31'h0, n < 100}, 32'h1);
    if (n >= 100)
      close_out();
    cmp({31'h0, (cyc - t0) >= 40 && (cyc - t0) <= 130}, 32'h1);
    if (r)
    begin
      rd(OFF_STATUS, 32'h60, RESP_OKAY);
      rd(OFF_ERROR, 32'h0, RESP_OKAY);
      rd(OFF_ERRLOG, 32'h1, RESP_OKAY);
    end
    else
      rd(OFF_ERROR, 32'h1, RESP_OKAY);
    wr(OFF_TLIMIT, 32'h0, RESP_OKAY);
  endtask

  initial
  begin
    arst_n = 1'h0;
    {cmd_start, rc, cmd_done, unc, idnf, abrt} = 6'h0;
    err_lba = 48'h0;
    bad_cnt = 16'h0;
    repeat (12) @(posedge clk);
    arst_n <= 1'h1;
    sc_reset();
    sc_plain();
    sc_stream();
    sc_timeout(1'h0);
    sc_timeout(1'h1);
    close_out();
  end
endmodule
`default_nettype wire
